// [src/spi_host_client_port.sv]
// Full-duplex serial port, host or client, with register port and interrupt
// Assumes pin inputs are asynchronous and an external pad resolves the enables
//
// Overview of operation
// - One 8-bit shifter, bit out and in together
// - Host pulls client select low per transfer
// - Host-to-client on MOSI, client-to-host on MISO
// - Host makes SCK from internal divider
// - Client synchronises SCK, edges trigger shifting
// - Data write: shifter normally, buffer when buffered
// - Data read: receive register or receive buffer
// - Seven host rates, fastest half system clock
// - Software picks LSB or MSB first
// - Enabled role forces listed pins to input
// - Output-direction pins take their level here
// - Client MISO driven only while selected
// - Transfer end raises interrupt-capable flag
// - Unbuffered write during transfer, or write to a full buffer, sets collision flag
// - Select low in host: become client, flag
// - Unbuffered host early write corrupts byte, flags collision
`timescale 1ns/10ps
`include "spi_port_defines.svh"

module spi_host_client_port (
  input  wire logic              i_clk_sys,
  input  wire logic              i_nrst,
  input  wire spi_port_pkg::reg_addr_t i_addr,
  input  wire spi_port_pkg::byte_t     i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output spi_port_pkg::byte_t          o_rdata,
  output logic                   o_irq,
  input  wire logic              i_mosi,
  output logic                   o_mosi,
  output logic                   o_mosi_oe,
  input  wire logic              i_miso,
  output logic                   o_miso,
  output logic                   o_miso_oe,
  input  wire logic              i_sck,
  output logic                   o_sck,
  output logic                   o_sck_oe,
  input  wire logic              i_ss_n,
  output logic                   o_ss_n,
  output logic                   o_ss_n_oe
);
  import spi_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic        en_ff, host_ff, lsbf_ff, clk2x_ff, bufen_ff, ssd_ff;
  logic [1:0]  presc_ff;
  logic [3:0]  dir_ff;
  logic [1:0]  stat_ff, ien_ff;
  byte_t       shift_ff, rx_data_ff, rx_buf_ff, txbuf_ff, rdata_ff;
  logic        txbuf_vld_ff, sck_ff, smp_ff;
  host_state_t state_ff;
  logic [6:0]  half_cnt_ff, half_max;
  logic [2:0]  bit_cnt_ff;
  logic [3:0]  s1_ff, s2_ff;
  logic        sck_d_ff;

  logic wr_data, is_host, is_client, ss_in, ss_lost, tick, h_rise, h_fall;
  logic c_act, c_rise, c_fall, smp_ev, sh_ev, done, busy, load_norm;
  logic pull, write_collision_flag_ev, start, out_bit;
  logic [1:0] clr_bits;
  byte_t nxt_shift;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the second stage is read
  // Resets to idle pin levels, SCK low, so no false edge follows reset
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_ff    <= `SPI_RST_SYNC;
      s2_ff    <= `SPI_RST_SYNC;
      sck_d_ff <= 1'b0;
    end else begin
      s1_ff    <= {i_ss_n, i_sck, i_miso, i_mosi};
      s2_ff    <= s1_ff;
      sck_d_ff <= s2_ff[`SPI_PIN_SCK];
    end
  end

  assign wr_data   = i_wr && (i_addr == `SPI_ADDR_DATA);
  assign clr_bits  = (i_wr && (i_addr == `SPI_ADDR_CLR)) ? i_wdata[1:0] : 2'h0;
  assign is_host   = en_ff & host_ff;
  assign is_client = en_ff & ~host_ff;
  assign ss_in     = s2_ff[`SPI_PIN_SS];
  assign ss_lost   = is_host & ~ssd_ff & ~dir_ff[`SPI_PIN_SS] & ~ss_in;

  // Divider table: presc picks /4../128, clk2x halves it to reach /2
  always_comb begin
    unique case (presc_ff)
      2'h0: half_max = `SPI_HALF_P0;
      2'h1: half_max = `SPI_HALF_P1;
      2'h2: half_max = `SPI_HALF_P2;
      2'h3: half_max = `SPI_HALF_P3;
    endcase
    if (clk2x_ff) begin
      half_max = half_max >> 1;
    end
  end

  assign tick   = (state_ff == ST_RUN) && (half_cnt_ff == 7'h00);
  assign h_rise = tick & ~sck_ff;
  assign h_fall = tick & sck_ff;
  // Edge detect needs each SCK phase over one cycle or edges are missed
  assign c_act  = is_client & ~ss_in;
  assign c_rise = c_act & s2_ff[`SPI_PIN_SCK] & ~sck_d_ff;
  assign c_fall = c_act & ~s2_ff[`SPI_PIN_SCK] & sck_d_ff;
  assign smp_ev = h_rise | c_rise;
  assign sh_ev  = h_fall | c_fall;
  assign done   = sh_ev && (bit_cnt_ff == `SPI_BIT_LAST);
  assign busy   = (state_ff == ST_RUN) || (bit_cnt_ff != 3'h0);

  assign nxt_shift = lsbf_ff ? {smp_ff, shift_ff[7:1]} : {shift_ff[6:0], smp_ff};
  assign out_bit   = lsbf_ff ? shift_ff[0] : shift_ff[7];

  // Unbuffered host early write still loads the shifter: the byte on the wire is spoilt
  assign load_norm = wr_data & ~bufen_ff & (is_host | ~busy);
  assign pull      = bufen_ff & txbuf_vld_ff & ~busy & ~sh_ev;
  assign write_collision_flag_ev  = wr_data & (bufen_ff ? txbuf_vld_ff : busy);
  assign start     = is_host & (state_ff == ST_IDLE) & ~ss_lost
                     & ((wr_data & ~bufen_ff) | pull);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      en_ff    <= 1'b0;
      lsbf_ff  <= 1'b0;
      clk2x_ff <= 1'b0;
      presc_ff <= 2'h0;
      bufen_ff <= 1'b0;
      ssd_ff   <= 1'b0;
      dir_ff   <= `SPI_RST_DIR;
      ien_ff   <= `SPI_RST_EV;
    end else if (i_wr) begin
      unique case (i_addr)
        `SPI_ADDR_CTRLA: begin
          en_ff    <= i_wdata[`SPI_CA_EN];
          lsbf_ff  <= i_wdata[`SPI_CA_LSBF];
          clk2x_ff <= i_wdata[`SPI_CA_CLK2X];
          presc_ff <= i_wdata[`SPI_CA_PRESC];
        end
        `SPI_ADDR_CTRLB: begin
          bufen_ff <= i_wdata[`SPI_CB_BUFEN];
          ssd_ff   <= i_wdata[`SPI_CB_SSD];
        end
        `SPI_ADDR_DIR: dir_ff <= i_wdata[3:0];
        `SPI_ADDR_IEN: ien_ff <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Losing the bus overrides a same-cycle write of the host bit
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      host_ff <= 1'b0;
    end else if (ss_lost) begin
      host_ff <= 1'b0;
    end else if (i_wr && (i_addr == `SPI_ADDR_CTRLA)) begin
      host_ff <= i_wdata[`SPI_CA_HOST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_ff <= `SPI_RST_BYTE;
    end else if (load_norm) begin
      shift_ff <= i_wdata;
    end else if (pull) begin
      shift_ff <= txbuf_ff;
    end else if (sh_ev) begin
      shift_ff <= nxt_shift;
    end
  end

  // Host MISO returns on our own SCK, so it is captured once at the rise;
  // the two-cycle synchroniser lag would lose bits at the fast rates
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      smp_ff <= 1'b0;
    end else if (smp_ev) begin
      smp_ff <= is_host ? i_miso : s2_ff[`SPI_PIN_MOSI];
    end
  end

  // Select going high in client role drops a partial byte
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_cnt_ff <= 3'h0;
    end else if (!en_ff || ss_lost || (is_client && ss_in)) begin
      bit_cnt_ff <= 3'h0;
    end else if (sh_ev) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      txbuf_ff     <= `SPI_RST_BYTE;
      txbuf_vld_ff <= 1'b0;
    end else if (!en_ff || !bufen_ff) begin
      txbuf_vld_ff <= 1'b0;
    end else if (wr_data && !txbuf_vld_ff) begin
      txbuf_ff     <= i_wdata;
      txbuf_vld_ff <= 1'b1;
    end else if (pull) begin
      txbuf_vld_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_data_ff <= `SPI_RST_BYTE;
      rx_buf_ff  <= `SPI_RST_BYTE;
    end else if (done && bufen_ff) begin
      rx_buf_ff  <= nxt_shift;
    end else if (done) begin
      rx_data_ff <= nxt_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host clock generator
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
    end else if (!is_host || ss_lost || done) begin
      state_ff <= ST_IDLE;
    end else if (start) begin
      state_ff <= ST_RUN;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_ff      <= 1'b0;
      half_cnt_ff <= 7'h00;
    end else if (start) begin
      sck_ff      <= 1'b0;
      half_cnt_ff <= half_max - 7'h01;
    end else if (state_ff != ST_RUN) begin
      sck_ff      <= 1'b0;
    end else if (tick) begin
      sck_ff      <= ~sck_ff;
      half_cnt_ff <= half_max - 7'h01;
    end else begin
      half_cnt_ff <= half_cnt_ff - 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: a set in the clear cycle wins
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      stat_ff <= `SPI_RST_EV;
    end else begin
      stat_ff[`SPI_EV_IF] <= (done | ss_lost)
                             | (stat_ff[`SPI_EV_IF] & ~clr_bits[`SPI_EV_IF]);
      stat_ff[`SPI_EV_WRITE_COLLISION_FLAG] <= write_collision_flag_ev
                                | (stat_ff[`SPI_EV_WRITE_COLLISION_FLAG] & ~clr_bits[`SPI_EV_WRITE_COLLISION_FLAG]);
    end
  end

  assign o_irq = |(stat_ff & ien_ff);

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= `SPI_RST_BYTE;
    end else if (!i_rd) begin
      rdata_ff <= 8'h00;
    end else begin
      unique case (i_addr)
        `SPI_ADDR_CTRLA: rdata_ff <= {2'h0, presc_ff, clk2x_ff, lsbf_ff, host_ff, en_ff};
        `SPI_ADDR_CTRLB: rdata_ff <= {6'h00, ssd_ff, bufen_ff};
        `SPI_ADDR_DATA:  rdata_ff <= bufen_ff ? rx_buf_ff : rx_data_ff;
        `SPI_ADDR_DIR:   rdata_ff <= {4'h0, dir_ff};
        `SPI_ADDR_STAT:  rdata_ff <= {6'h00, stat_ff};
        `SPI_ADDR_IEN:   rdata_ff <= {6'h00, ien_ff};
        `SPI_ADDR_LVL:   rdata_ff <= {6'h00, busy, ~txbuf_vld_ff};
        default:         rdata_ff <= 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pins: enables follow role and direction, the pad resolves the wire
  assign o_mosi    = out_bit;
  assign o_mosi_oe = is_host & dir_ff[`SPI_PIN_MOSI];
  assign o_miso    = out_bit;
  assign o_miso_oe = is_client & dir_ff[`SPI_PIN_MISO] & ~ss_in;
  assign o_sck     = sck_ff;
  assign o_sck_oe  = is_host & dir_ff[`SPI_PIN_SCK];
  assign o_ss_n    = (state_ff != ST_RUN);
  assign o_ss_n_oe = is_host & dir_ff[`SPI_PIN_SS];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  a_done_flag_set: assert property (done |=> stat_ff[`SPI_EV_IF])
    else $error("transfer end did not set flag");
  a_done_rx_store: assert property (done && !bufen_ff |=> rx_data_ff == $past(nxt_shift))
    else $error("received byte not stored");
  a_write_collision_flag_flag_set: assert property (write_collision_flag_ev |=> stat_ff[`SPI_EV_WRITE_COLLISION_FLAG])
    else $error("collision not flagged");
  a_host_bus_loss: assert property (ss_lost |=> !host_ff && stat_ff[0] && state_ff == ST_IDLE)
    else $error("bus loss not handled");
  a_client_pins_in: assert property (is_client |-> !o_mosi_oe && !o_sck_oe && !o_ss_n_oe)
    else $error("client drives an input pin");
  a_miso_tristate: assert property ((is_client && ss_in) || is_host |-> !o_miso_oe)
    else $error("miso driven while deselected");
  a_host_start_sel: assert property (start |=> state_ff == ST_RUN && !o_ss_n && !o_sck)
    else $error("select not low at start");
  a_normal_write: assert property (wr_data && !bufen_ff && is_host |=> shift_ff == $past(i_wdata))
    else $error("data write did not load shifter");
  a_data_read: assert property (i_rd && i_addr == `SPI_ADDR_DATA && !bufen_ff
                                |=> o_rdata == $past(rx_data_ff))
    else $error("data read wrong source");
  a_fast_rate: assert property (start && clk2x_ff && presc_ff == 2'h0 |=> ##1 o_sck ##1 !o_sck)
    else $error("fastest rate not half clock");
  a_client_wr_drop: assert property (wr_data && is_client && busy && !bufen_ff && !sh_ev
                                     |=> shift_ff == $past(shift_ff))
    else $error("client early write reached shifter");
  a_mosi_hold: assert property (is_host && sck_ff && !sh_ev && !i_wr |=> $stable(o_mosi))
    else $error("mosi moved while sck high");
  a_client_sel_drop: assert property (is_client && ss_in |=> bit_cnt_ff == 3'h0)
    else $error("partial byte kept after deselect");
  a_if_clear: assert property (clr_bits[`SPI_EV_IF] && !done && !ss_lost
                               |=> !stat_ff[`SPI_EV_IF])
    else $error("transfer flag not cleared");
  a_write_collision_flag_clear: assert property (clr_bits[`SPI_EV_WRITE_COLLISION_FLAG] && !write_collision_flag_ev
                                  |=> !stat_ff[`SPI_EV_WRITE_COLLISION_FLAG])
    else $error("collision flag not cleared");
  a_txbuf_pull: assert property (pull |=> shift_ff == $past(txbuf_ff))
    else $error("buffered byte not moved to shifter");

  c_host_done: cover property (is_host && done);
  c_client_done: cover property (is_client && done);
  c_bus_loss: cover property (ss_lost);
  c_collision: cover property (write_collision_flag_ev);
  c_buffered_done: cover property (done && bufen_ff);
endmodule

// [src/spi_port_defines.svh]
// Register offsets, field positions, reset values and clock dividers
// Assumes 3-bit register index, 8-bit data, one register per index
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

`define SPI_ADDR_CTRLA 3'h0
`define SPI_ADDR_CTRLB 3'h1
`define SPI_ADDR_DATA  3'h2
`define SPI_ADDR_DIR   3'h3
`define SPI_ADDR_STAT  3'h4
`define SPI_ADDR_CLR   3'h5
`define SPI_ADDR_IEN   3'h6
`define SPI_ADDR_LVL   3'h7

`define SPI_CA_EN    0
`define SPI_CA_HOST  1
`define SPI_CA_LSBF  2
`define SPI_CA_CLK2X 3
`define SPI_CA_PRESC 5:4
`define SPI_CB_BUFEN 0
`define SPI_CB_SSD   1

`define SPI_PIN_MOSI 0
`define SPI_PIN_MISO 1
`define SPI_PIN_SCK  2
`define SPI_PIN_SS   3

`define SPI_EV_IF    0
`define SPI_EV_WRITE_COLLISION_FLAG 1

`define SPI_RST_BYTE 8'h00
`define SPI_RST_EV   2'h0
`define SPI_RST_DIR  4'h0
`define SPI_RST_SYNC 4'hB

`define SPI_HALF_P0  7'h02
`define SPI_HALF_P1  7'h08
`define SPI_HALF_P2  7'h20
`define SPI_HALF_P3  7'h40
`define SPI_BIT_LAST 3'h7

`endif

// [src/spi_port_pkg.sv]
// Types shared by the serial port design
// Assumes the defines header supplies all numeric constants
package spi_port_pkg;
  typedef logic [2:0] reg_addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic {ST_IDLE, ST_RUN} host_state_t;
endpackage

// [tb/spi_host_client_port_tb.sv]
// Self-checking bench: host rates, bit order, collisions, bus loss, client
// Assumes the design's assertions sit in the design files
`timescale 1ns/10ps
`include "spi_port_defines.svh"
module spi_host_client_port_tb;
  import spi_port_pkg::*;
  logic      i_clk_sys, i_nrst, i_wr, i_rd, p_host;
  reg_addr_t i_addr;
  byte_t     i_wdata, o_rdata, d, p, r;
  logic      o_irq, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_sck, o_sck_oe, o_ss_n, o_ss_n_oe;
  logic      p_sck, p_mosi, p_miso, p_ss_n;
  wire logic w_sck, w_mosi, w_miso, w_ss_n;
  int        mismatches, check_count, cycles, seed, hi, rises, bad;
  int        pr[7] = '{0, 0, 1, 1, 2, 2, 3};
  int        c2[7] = '{1, 0, 1, 0, 1, 0, 0};
  int        hp[7] = '{1, 2, 4, 8, 16, 32, 64};

  assign w_sck  = o_sck_oe  ? o_sck  : p_sck;
  assign w_mosi = o_mosi_oe ? o_mosi : p_mosi;
  assign w_miso = o_miso_oe ? o_miso : p_miso;
  assign w_ss_n = o_ss_n_oe ? o_ss_n : p_ss_n;

  spi_host_client_port dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_mosi(w_mosi), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe), .i_miso(w_miso),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe), .i_sck(w_sck), .o_sck(o_sck),
    .o_sck_oe(o_sck_oe), .i_ss_n(w_ss_n), .o_ss_n(o_ss_n), .o_ss_n_oe(o_ss_n_oe));
  spi_remote_model partner (.i_host_role(p_host), .i_sck(w_sck), .i_mosi(w_mosi),
    .i_miso(w_miso), .i_ss_n(w_ss_n), .o_sck(p_sck), .o_mosi(p_mosi), .o_miso(p_miso),
    .o_ss_n(p_ss_n));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("mismatches=%0d comparisons=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run is a few thousand cycles; this only cuts a hang
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run;
    end
  end

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr(input reg_addr_t a, input byte_t v);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task rchk(input string what, input reg_addr_t a, input byte_t exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    chk(what, o_rdata, exp);
  endtask

  function automatic byte_t rev8(input byte_t b);
    byte_t o;
    for (int i = 0; i < 8; i++) o[i] = b[7 - i];
    return o;
  endfunction

  // Bounded wait for the interrupt while profiling SCK and select
  task wait_irq;
    int n;
    logic prev;
    n = 0;
    prev = 1'b0;
    hi = 0;
    rises = 0;
    bad = 0;
    while (o_irq !== 1'b1 && n < 2000) begin
      @(negedge i_clk_sys);
      n++;
      hi += int'(o_sck);
      rises += int'(o_sck && !prev);
      bad += int'(o_sck && o_ss_n);
      prev = o_sck;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 11555;
    {mismatches, check_count, cycles} = '0;
    {i_nrst, i_wr, i_rd, i_addr, i_wdata, p_host} = '0;
    repeat (3) @(posedge i_clk_sys);
    chk("reset pins", {o_mosi_oe, o_miso_oe, o_sck_oe, o_ss_n_oe, o_ss_n, o_irq}, 6'h02);
    i_nrst <= 1'b1;
    for (int a = 0; a < 8; a++)
      rchk("reset reg", reg_addr_t'(a), (a == `SPI_ADDR_LVL) ? 8'h01 : 8'h00);
    wr(`SPI_ADDR_DIR, 8'h0D);
    wr(`SPI_ADDR_IEN, 8'h03);
    for (int k = 0; k < 7; k++) begin
      d = byte_t'($random(seed));
      p = byte_t'($random(seed));
      partner.tx = p;
      wr(`SPI_ADDR_CTRLB, {7'h00, k == 6});
      wr(`SPI_ADDR_CTRLA, {2'b00, 2'(pr[k]), 1'(c2[k]), 1'(k % 2), 2'b11});
      wr(`SPI_ADDR_DATA, d);
      wait_irq;
      chk("sck rises", 16'(rises), 16'h0008);
      chk("sck high", 16'(hi), 16'(8 * hp[k]));
      chk("sck without select", 16'(bad), 16'h0000);
      rchk("status", `SPI_ADDR_STAT, 8'h01);
      rchk("rx", `SPI_ADDR_DATA, (k % 2) ? rev8(p) : p);
      chk("remote rx", partner.rx, (k % 2) ? rev8(d) : d);
      wr(`SPI_ADDR_CLR, 8'h03);
      @(negedge i_clk_sys);
      chk("irq cleared", o_irq, 1'b0);
    end
    // Collision raises the line early, so wait on the transfer flag alone
    wr(`SPI_ADDR_IEN, 8'h01);
    wr(`SPI_ADDR_CTRLB, 8'h00);
    wr(`SPI_ADDR_CTRLA, 8'h13);
    wr(`SPI_ADDR_DATA, d);
    wr(`SPI_ADDR_DATA, ~d);
    wait_irq;
    rchk("collision", `SPI_ADDR_STAT, 8'h03);
    wr(`SPI_ADDR_IEN, 8'h00);
    @(negedge i_clk_sys);
    chk("irq masked", o_irq, 1'b0);
    wr(`SPI_ADDR_IEN, 8'h03);
    wr(`SPI_ADDR_CLR, 8'h03);
    // Select as input: another host pulls it low
    wr(`SPI_ADDR_DIR, 8'h07);
    p_host = 1'b1;
    partner.frame(8'hA5, 80);
    rchk("host bit", `SPI_ADDR_CTRLA, 8'h11);
    rchk("loss flag", `SPI_ADDR_STAT, 8'h01);
    wr(`SPI_ADDR_CLR, 8'h03);
    wr(`SPI_ADDR_CTRLA, 8'h01);
    wr(`SPI_ADDR_DIR, 8'h0F);
    @(negedge i_clk_sys);
    chk("client oe", {o_mosi_oe, o_miso_oe, o_sck_oe, o_ss_n_oe}, 4'h0);
    for (int j = 0; j < 3; j++) begin
      d = byte_t'($random(seed));
      p = byte_t'($random(seed));
      wr(`SPI_ADDR_DATA, d);
      fork
        partner.frame(p, 80);
        begin
          repeat (40) @(posedge i_clk_sys);
          chk("miso oe", o_miso_oe, 1'b1);
          if (j == 2) wr(`SPI_ADDR_DATA, ~d);
        end
      join
      repeat (8) @(posedge i_clk_sys);
      rchk("client status", `SPI_ADDR_STAT, (j == 2) ? 8'h03 : 8'h01);
      rchk("client rx", `SPI_ADDR_DATA, p);
      chk("host rx", partner.rx, d);
      wr(`SPI_ADDR_CLR, 8'h03);
    end
    chk("miso released", o_miso_oe, 1'b0);
    complete_run;
  end
endmodule

// [tb/spi_remote_model.sv]
// Remote serial party: mode 0 client, or host making framed SCK
// Assumes the bench resolves every pin from the port's enables alone
`timescale 1ns/10ps
module spi_remote_model (
  input  wire logic i_host_role,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_miso,
  input  wire logic i_ss_n,
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_miso,
  output logic      o_ss_n
);
  import spi_port_pkg::*;
  byte_t tx;
  byte_t rx;

  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_miso = 1'b0;
    o_ss_n = 1'b1;
    tx = 8'h00;
    rx = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Client side, MSB first
  always @(negedge i_ss_n) if (!i_host_role) o_miso = tx[7];
  always @(posedge i_sck) if (!i_host_role && !i_ss_n) rx = {rx[6:0], i_mosi};
  always @(negedge i_sck) if (!i_host_role && !i_ss_n) begin
    tx = {tx[6:0], 1'b0};
    o_miso = tx[7];
  end
  // Released line shows the inverse, so a stale bit never passes
  always @(posedge i_ss_n) if (!i_host_role) o_miso = ~o_miso;

  ////////////////////////////////////////////////////////////////////////////
  // Host side: SCK only moves inside the frame
  task automatic frame(input byte_t d, input int half);
    #3 o_ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_mosi = d[i];
      #(half) o_sck = 1'b1;
      rx = {rx[6:0], i_miso};
      #(half) o_sck = 1'b0;
    end
    #(half) o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
  endtask
endmodule
